// ---- cfg_host_model.sv ----
`default_nettype none
module cfg_host_model
(
  // Clock
  input  wire logic       clk,
  // Request side from the bench
  input  wire logic       reqStart,
  input  wire logic       reqWrite,
  input  wire logic [7:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic            reqDone,
  output logic [7:0]      rspData,
  // Register port towards the hub
  output logic [7:0]      cfgAddr,
  output logic            cfgWrEn,
  output logic [7:0]      cfgWrData,
  output logic            cfgRdEn,
  input  wire logic [7:0] cfgRdData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] step;

  // Idle bus at time zero
  initial
  begin
    step      = 2'd0;
    reqDone   = 1'b0;
    rspData   = 8'h00;
    cfgAddr   = 8'h00;
    cfgWrEn   = 1'b0;
    cfgWrData = 8'h00;
    cfgRdEn   = 1'b0;
  end

  // One-cycle strobe, then release; read data taken one edge after the read edge
  always @(posedge clk)
  begin
    reqDone <= 1'b0;
    case (step)
      2'd0:
        if (reqStart)
        begin
          cfgAddr   <= reqAddr;
          cfgWrData <= reqData;
          cfgWrEn   <= reqWrite;
          cfgRdEn   <= !reqWrite;
          step      <= 2'd1;
        end
      2'd1:
      begin
        cfgWrEn   <= 1'b0;
        cfgRdEn   <= 1'b0;
        cfgAddr   <= ~cfgAddr;   // Released lines do not keep the last value
        cfgWrData <= ~cfgWrData;
        reqDone   <= cfgWrEn;
        step      <= cfgWrEn ? 2'd0 : 2'd2;
      end
      default:
      begin
        rspData <= cfgRdData;
        reqDone <= 1'b1;
        step    <= 2'd0;
      end
    endcase
  end
endmodule : cfg_host_model
`default_nettype wire

// ---- hub_cfg_pkg.sv ----
`default_nettype none
package hub_cfg_pkg;

  // Register offsets on the internal configuration memory port
  localparam logic [7:0] OFS_POWER_CONFIG_BYTE_TWO      = 8'h08;
  localparam logic [7:0] OFS_FIXED_PORT_MASK            = 8'h09;
  localparam logic [7:0] OFS_SELF_POWERED_PORT_OFF_MASK = 8'h0a;
  localparam logic [7:0] OFS_BUS_POWERED_PORT_OFF_MASK  = 8'h0b;
  localparam logic [7:0] OFS_SELF_POWERED_CURRENT_BUDGET = 8'h0c;

  // Reset values
  localparam logic [7:0] RST_REG_VALUE = 8'h00;
  localparam logic [7:0] UNDEF_READ    = 8'h00;

  // Field positions in the second configuration byte
  localparam int AUTO_SWITCH_BIT = 7;
  localparam int OC_DELAY_MSB    = 5;
  localparam int OC_DELAY_LSB    = 4;
  localparam int COMPOUND_BIT    = 3;

  // Port bits in the mask registers
  localparam int PORT_MSB      = 3;
  localparam int PORT_LSB      = 1;
  localparam int RSVD_ZERO_BIT = 0;

  // Over-current delay encodings
  typedef enum logic [1:0] {
    OC_DLY_0P1MS = 2'h0,
    OC_DLY_2MS   = 2'h1,
    OC_DLY_4MS   = 2'h2,
    OC_DLY_6MS   = 2'h3
  } oc_delay_t;

  // Clock and over-current delay times
  localparam int CLK_PERIOD_NS  = 100;
  localparam int OC_TIME_A_US   = 100;
  localparam int OC_TIME_B_US   = 2000;
  localparam int OC_TIME_C_US   = 4000;
  localparam int OC_TIME_D_US   = 6000;
  localparam int NS_PER_US      = 1000;
  localparam int OC_CNT_W       = 16;
  localparam int OC_CYCLES_A    = (OC_TIME_A_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CYCLES_B    = (OC_TIME_B_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CYCLES_C    = (OC_TIME_C_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CYCLES_D    = (OC_TIME_D_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Current budget step of two milliamps
  localparam int BUDGET_MA_W = 9;

  // Over-current timer states, Gray along idle, counting, tripped
  typedef enum logic [1:0] {
    OC_IDLE  = 2'b00,
    OC_COUNT = 2'b01,
    OC_TRIP  = 2'b11
  } oc_state_t;

endpackage : hub_cfg_pkg
`default_nettype wire

// ---- hub_power_port_config_regs.sv ----
`default_nettype none
module hub_power_port_config_regs #(
  parameter int unsigned OC_CYC_A = hub_cfg_pkg::OC_CYCLES_A,
  parameter int unsigned OC_CYC_B = hub_cfg_pkg::OC_CYCLES_B,
  parameter int unsigned OC_CYC_C = hub_cfg_pkg::OC_CYCLES_C,
  parameter int unsigned OC_CYC_D = hub_cfg_pkg::OC_CYCLES_D
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Configuration memory port
  input  wire logic [7:0]  cfgAddr,
  input  wire logic        cfgWrEn,
  input  wire logic [7:0]  cfgWrData,
  input  wire logic        cfgRdEn,
  output logic [7:0]       cfgRdData,
  // Memory control
  input  wire logic        cfgSoftReset,
  input  wire logic        cfgWriteLock,
  // Power sensing
  input  wire logic        localSupplySensePin,
  input  wire logic        powerSourceSelect,
  input  wire logic        overcurrentSense,
  // Consumed configuration
  output logic             selfPoweredActive,
  output logic             autoSwitchEnabled,
  output logic             compoundDevice,
  output logic [3:1]       fixedPorts,
  output logic [3:1]       portAvailable,
  output logic [8:0]       selfPoweredBudgetMa,
  output logic             overcurrentTrip
);
  import hub_cfg_pkg::*;

  logic [7:0] cfgByteTwo_q, cfgByteTwo_d;
  logic [7:0] fixedMask_q, fixedMask_d;
  logic [7:0] spOffMask_q, spOffMask_d;
  logic [7:0] bpOffMask_q, bpOffMask_d;
  logic [7:0] budget_q, budget_d;
  logic [7:0] rdData_q, rdData_d;
  logic       selfPowered_q, selfPowered_d;
  logic       autoSw_q, autoSw_d;
  logic       compound_q, compound_d;
  logic [3:1] fixedPorts_q, fixedPorts_d;
  logic [3:1] portAvail_q, portAvail_d;
  logic [8:0] budgetMa_q, budgetMa_d;
  logic       wrAllowed;

  // Port bits kept, reserved bit 0 forced low
  function automatic logic [7:0] maskClean(input logic [7:0] v);
    maskClean = v;
    maskClean[RSVD_ZERO_BIT] = 1'b0;
  endfunction : maskClean

  // Address recognised by this bank
  function automatic logic isDefined(input logic [7:0] a);
    isDefined = (a == OFS_POWER_CONFIG_BYTE_TWO) || (a == OFS_FIXED_PORT_MASK)
             || (a == OFS_SELF_POWERED_PORT_OFF_MASK) || (a == OFS_BUS_POWERED_PORT_OFF_MASK)
             || (a == OFS_SELF_POWERED_CURRENT_BUDGET);
  endfunction : isDefined

  assign wrAllowed = cfgWrEn && !cfgWriteLock;

  // Register writes, soft reset has priority
  always_comb
  begin
    cfgByteTwo_d = cfgByteTwo_q;
    fixedMask_d  = fixedMask_q;
    spOffMask_d  = spOffMask_q;
    bpOffMask_d  = bpOffMask_q;
    budget_d     = budget_q;
    if (cfgSoftReset)
    begin
      cfgByteTwo_d = RST_REG_VALUE;
      fixedMask_d  = RST_REG_VALUE;
      spOffMask_d  = RST_REG_VALUE;
      bpOffMask_d  = RST_REG_VALUE;
      budget_d     = RST_REG_VALUE;
    end
    else if (wrAllowed)
    begin
      if (cfgAddr == OFS_POWER_CONFIG_BYTE_TWO)
        cfgByteTwo_d = cfgWrData;
      else if (cfgAddr == OFS_FIXED_PORT_MASK)
        fixedMask_d = maskClean(cfgWrData);
      else if (cfgAddr == OFS_SELF_POWERED_PORT_OFF_MASK)
        spOffMask_d = maskClean(cfgWrData);
      else if (cfgAddr == OFS_BUS_POWERED_PORT_OFF_MASK)
        bpOffMask_d = maskClean(cfgWrData);
      else if (cfgAddr == OFS_SELF_POWERED_CURRENT_BUDGET)
        budget_d = cfgWrData;
      // Other addresses: write dropped silently
    end
  end

  // Registered read data
  always_comb
  begin
    rdData_d = rdData_q;
    if (cfgRdEn)
    begin
      if (cfgAddr == OFS_POWER_CONFIG_BYTE_TWO)
        rdData_d = cfgByteTwo_q;
      else if (cfgAddr == OFS_FIXED_PORT_MASK)
        rdData_d = fixedMask_q;
      else if (cfgAddr == OFS_SELF_POWERED_PORT_OFF_MASK)
        rdData_d = spOffMask_q;
      else if (cfgAddr == OFS_BUS_POWERED_PORT_OFF_MASK)
        rdData_d = bpOffMask_q;
      else if (cfgAddr == OFS_SELF_POWERED_CURRENT_BUDGET)
        rdData_d = budget_q;
      else
        rdData_d = UNDEF_READ;
    end
  end

  // Power source and port availability
  always_comb
  begin
    autoSw_d = cfgByteTwo_q[AUTO_SWITCH_BIT];
    if (autoSw_d)
      selfPowered_d = localSupplySensePin;
    else
      selfPowered_d = powerSourceSelect;
    if (selfPowered_d)
      portAvail_d = ~spOffMask_q[PORT_MSB:PORT_LSB];
    else
      portAvail_d = ~bpOffMask_q[PORT_MSB:PORT_LSB];
    compound_d   = cfgByteTwo_q[COMPOUND_BIT];
    fixedPorts_d = fixedMask_q[PORT_MSB:PORT_LSB];
    budgetMa_d   = {budget_q, 1'b0};
  end

  // All state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfgByteTwo_q  <= RST_REG_VALUE;
      fixedMask_q   <= RST_REG_VALUE;
      spOffMask_q   <= RST_REG_VALUE;
      bpOffMask_q   <= RST_REG_VALUE;
      budget_q      <= RST_REG_VALUE;
      rdData_q      <= UNDEF_READ;
      selfPowered_q <= 1'b0;
      autoSw_q      <= 1'b0;
      compound_q    <= 1'b0;
      fixedPorts_q  <= '0;
      portAvail_q   <= '0;
      budgetMa_q    <= '0;
    end
    else
    begin
      cfgByteTwo_q  <= cfgByteTwo_d;
      fixedMask_q   <= fixedMask_d;
      spOffMask_q   <= spOffMask_d;
      bpOffMask_q   <= bpOffMask_d;
      budget_q      <= budget_d;
      rdData_q      <= rdData_d;
      selfPowered_q <= selfPowered_d;
      autoSw_q      <= autoSw_d;
      compound_q    <= compound_d;
      fixedPorts_q  <= fixedPorts_d;
      portAvail_q   <= portAvail_d;
      budgetMa_q    <= budgetMa_d;
    end
  end

  // Over-current filter with the selected delay
  overcurrent_delay_timer #(
    .CYC_A (OC_CYC_A),
    .CYC_B (OC_CYC_B),
    .CYC_C (OC_CYC_C),
    .CYC_D (OC_CYC_D)
  ) ocTimer (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .overcurrentSense       (overcurrentSense),
    .overcurrentDelaySelect (oc_delay_t'(cfgByteTwo_q[OC_DELAY_MSB:OC_DELAY_LSB])),
    .overcurrentTrip        (overcurrentTrip)
  );

  // Outputs straight from flops
  assign cfgRdData           = rdData_q;
  assign selfPoweredActive   = selfPowered_q;
  assign autoSwitchEnabled   = autoSw_q;
  assign compoundDevice      = compound_q;
  assign fixedPorts          = fixedPorts_q;
  assign portAvailable       = portAvail_q;
  assign selfPoweredBudgetMa = budgetMa_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  autoFollow_a: assert property (cfgByteTwo_q[AUTO_SWITCH_BIT] |=>
      selfPowered_q == $past(localSupplySensePin))
    else $error("auto switching did not follow supply sense");
  fixedSource_a: assert property (!cfgByteTwo_q[AUTO_SWITCH_BIT] |=>
      selfPowered_q == $past(powerSourceSelect))
    else $error("power source changed without auto switching");
  compoundFlag_a: assert property (##1 compoundDevice == $past(cfgByteTwo_q[COMPOUND_BIT]))
    else $error("compound flag mismatch");
  fixedMask_a: assert property (##1 !$past(fixedMask_q[RSVD_ZERO_BIT])
      && fixedPorts == $past(fixedMask_q[PORT_MSB:PORT_LSB]))
    else $error("fixed port mask wrong");
  spMaskApply_a: assert property (selfPoweredActive |->
      portAvailable == ~$past(spOffMask_q[PORT_MSB:PORT_LSB]) && !spOffMask_q[RSVD_ZERO_BIT])
    else $error("self-powered mask not applied");
  bpMaskApply_a: assert property (##1 !selfPoweredActive |->
      portAvailable == ~$past(bpOffMask_q[PORT_MSB:PORT_LSB]) && !bpOffMask_q[RSVD_ZERO_BIT])
    else $error("bus-powered mask not applied");
  maskReselect_a: assert property ($changed(localSupplySensePin) && autoSw_q
      && cfgByteTwo_q[AUTO_SWITCH_BIT] && spOffMask_q != bpOffMask_q
      && $stable(spOffMask_q) && $stable(bpOffMask_q) |=> $changed(selfPoweredActive))
    else $error("power source not reselected");
  budgetScale_a: assert property (##1 selfPoweredBudgetMa == 9'({$past(budget_q), 1'b0}))
    else $error("budget not in 2 mA steps");
  budgetFifty_a: assert property (budget_q == 8'h32 |=> selfPoweredBudgetMa == 9'h064)
    else $error("value 50 is not 100 mA");
  undefRead_a: assert property (cfgRdEn && !isDefined(cfgAddr) |=> cfgRdData == UNDEF_READ)
    else $error("undefined address read nonzero");
  undefWrite_a: assert property (cfgWrEn && !cfgSoftReset && !isDefined(cfgAddr) |=>
      $stable(cfgByteTwo_q) && $stable(fixedMask_q) && $stable(spOffMask_q)
      && $stable(bpOffMask_q) && $stable(budget_q))
    else $error("undefined write changed a register");
  softClear_a: assert property (cfgSoftReset |=> cfgByteTwo_q == 8'h00 && fixedMask_q == 8'h00
      && spOffMask_q == 8'h00 && bpOffMask_q == 8'h00 && budget_q == 8'h00)
    else $error("soft reset left a register set");

  // Registered copy of the auto switching bit
  autoFlag_a: assert property (##1 autoSwitchEnabled == $past(cfgByteTwo_q[AUTO_SWITCH_BIT]))
    else $error("auto switching flag mismatch");

  // Reserved bit 0 of the off masks never stored
  spMaskZero_a: assert property (!spOffMask_q[RSVD_ZERO_BIT])
    else $error("self-powered mask bit 0 set");
  bpMaskZero_a: assert property (!bpOffMask_q[RSVD_ZERO_BIT])
    else $error("bus-powered mask bit 0 set");

  // Accepted writes land in the addressed register
  byteTwoStore_a: assert property (wrAllowed && !cfgSoftReset
      && cfgAddr == OFS_POWER_CONFIG_BYTE_TWO |=> cfgByteTwo_q == $past(cfgWrData))
    else $error("config byte two write lost");
  budgetStore_a: assert property (wrAllowed && !cfgSoftReset
      && cfgAddr == OFS_SELF_POWERED_CURRENT_BUDGET |=> budget_q == $past(cfgWrData))
    else $error("budget write lost");

  // Reads of defined addresses return the stored byte
  byteTwoRead_a: assert property (cfgRdEn && cfgAddr == OFS_POWER_CONFIG_BYTE_TWO |=>
      cfgRdData == $past(cfgByteTwo_q))
    else $error("config byte two read wrong");
  fixedRead_a: assert property (cfgRdEn && cfgAddr == OFS_FIXED_PORT_MASK |=>
      cfgRdData == $past(fixedMask_q) && !cfgRdData[RSVD_ZERO_BIT])
    else $error("fixed port mask read wrong");
  spRead_a: assert property (cfgRdEn && cfgAddr == OFS_SELF_POWERED_PORT_OFF_MASK |=>
      cfgRdData == $past(spOffMask_q) && !cfgRdData[RSVD_ZERO_BIT])
    else $error("self-powered mask read wrong");
  bpRead_a: assert property (cfgRdEn && cfgAddr == OFS_BUS_POWERED_PORT_OFF_MASK |=>
      cfgRdData == $past(bpOffMask_q) && !cfgRdData[RSVD_ZERO_BIT])
    else $error("bus-powered mask read wrong");
  budgetRead_a: assert property (cfgRdEn && cfgAddr == OFS_SELF_POWERED_CURRENT_BUDGET |=>
      cfgRdData == $past(budget_q))
    else $error("budget read wrong");

  // Read data stands until the next read
  rdHold_a: assert property (!cfgRdEn |=> $stable(cfgRdData))
    else $error("read data changed without a read");

  // Scenario coverage

  autoSwitch_c: cover property (autoSw_q ##1 $fell(selfPoweredActive) ##[1:20] $rose(selfPoweredActive));
  undefRead_c: cover property (cfgRdEn && !isDefined(cfgAddr));
  budgetWrite_c: cover property (cfgWrEn && cfgAddr == OFS_SELF_POWERED_CURRENT_BUDGET);
  softReset_c: cover property (cfgSoftReset && cfgByteTwo_q != 8'h00);

endmodule : hub_power_port_config_regs
`default_nettype wire

// ---- overcurrent_delay_timer.sv ----
`default_nettype none
module overcurrent_delay_timer #(
  parameter int unsigned CYC_A = hub_cfg_pkg::OC_CYCLES_A,
  parameter int unsigned CYC_B = hub_cfg_pkg::OC_CYCLES_B,
  parameter int unsigned CYC_C = hub_cfg_pkg::OC_CYCLES_C,
  parameter int unsigned CYC_D = hub_cfg_pkg::OC_CYCLES_D
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Sense and selection
  input  wire logic                  overcurrentSense,
  input  wire hub_cfg_pkg::oc_delay_t overcurrentDelaySelect,
  // Filtered trip
  output logic                       overcurrentTrip
);
  import hub_cfg_pkg::*;

  oc_state_t             state_q, state_d;
  logic [OC_CNT_W-1:0]   cnt_q, cnt_d;
  logic                  trip_q, trip_d;
  logic [OC_CNT_W-1:0]   limit;

  // Delay lookup from the select field
  function automatic logic [OC_CNT_W-1:0] delayCycles(input oc_delay_t sel);
    case (sel)
      OC_DLY_0P1MS: delayCycles = OC_CNT_W'(CYC_A);
      OC_DLY_2MS:   delayCycles = OC_CNT_W'(CYC_B);
      OC_DLY_4MS:   delayCycles = OC_CNT_W'(CYC_C);
      default:      delayCycles = OC_CNT_W'(CYC_D);
    endcase
  endfunction : delayCycles

  assign limit = delayCycles(overcurrentDelaySelect);

  // Next state: trip only after the sense holds for the selected delay
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      OC_IDLE:
      begin
        if (overcurrentSense)
        begin
          state_d = OC_COUNT;
          cnt_d   = OC_CNT_W'(1);
        end
      end
      OC_COUNT:
      begin
        if (!overcurrentSense)
          state_d = OC_IDLE;
        else if (cnt_q >= limit)
          state_d = OC_TRIP;
        else
          cnt_d = cnt_q + OC_CNT_W'(1);
      end
      OC_TRIP:
      begin
        if (!overcurrentSense)
          state_d = OC_IDLE;
      end
      default: state_d = OC_IDLE;
    endcase
    trip_d = (state_d == OC_TRIP);
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= OC_IDLE;
      cnt_q   <= '0;
      trip_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trip_q  <= trip_d;
    end
  end

  assign overcurrentTrip = trip_q;

  // Helper: consecutive cycles of sense high
  logic [OC_CNT_W-1:0] holdCnt;
  always_ff @(posedge clk)
  begin
    if (sys_rst || !overcurrentSense)
      holdCnt <= '0;
    else if (holdCnt != {OC_CNT_W{1'b1}})
      holdCnt <= holdCnt + OC_CNT_W'(1);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  tripDelay_a: assert property ($rose(trip_q) |-> $past(holdCnt) >= $past(limit))
    else $error("over-current trip before selected delay");
  tripDrop_a: assert property (!overcurrentSense |=> !trip_q)
    else $error("trip held without sense");
  tripCov_c: cover property ($rose(trip_q));

endmodule : overcurrent_delay_timer
`default_nettype wire

// ---- test_hub_power_port_config_regs.sv ----
`default_nettype none
module test_hub_power_port_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import hub_cfg_pkg::*;

  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reqStart = 1'b0, reqWrite = 1'b0, reqDone;
  logic [7:0] reqAddr = 8'h00, reqData = 8'h00, rspData;
  logic [7:0] cfgAddr, cfgWrData, cfgRdData;
  logic       cfgWrEn, cfgRdEn;
  logic       cfgSoftReset = 1'b0, cfgWriteLock = 1'b0;
  logic       localSupplySensePin = 1'b0, powerSourceSelect = 1'b0, overcurrentSense = 1'b0;
  logic       selfPoweredActive, autoSwitchEnabled, compoundDevice, overcurrentTrip;
  logic [3:1] fixedPorts, portAvailable;
  logic [8:0] selfPoweredBudgetMa;
  int         failures = 0;
  int         n_tests = 0;
  int         n;
  int         cyc [4] = '{5, 10, 15, 20};
  logic [7:0] ofs [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};

  // 10 MHz clock
  always #50 clk = ~clk;

  cfg_host_model host (.clk(clk), .reqStart(reqStart), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqDone(reqDone), .rspData(rspData), .cfgAddr(cfgAddr),
    .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData));

  hub_power_port_config_regs #(.OC_CYC_A(5), .OC_CYC_B(10), .OC_CYC_C(15), .OC_CYC_D(20)) uut (
    .clk(clk), .sys_rst(sys_rst), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData),
    .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .cfgSoftReset(cfgSoftReset),
    .cfgWriteLock(cfgWriteLock), .localSupplySensePin(localSupplySensePin),
    .powerSourceSelect(powerSourceSelect), .overcurrentSense(overcurrentSense),
    .selfPoweredActive(selfPoweredActive), .autoSwitchEnabled(autoSwitchEnabled),
    .compoundDevice(compoundDevice), .fixedPorts(fixedPorts), .portAvailable(portAvailable),
    .selfPoweredBudgetMa(selfPoweredBudgetMa), .overcurrentTrip(overcurrentTrip));

  // Counts, verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  // One register access through the host model, bounded wait
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    reqStart <= 1'b1;
    reqWrite <= wr;
    reqAddr  <= a;
    reqData  <= d;
    @(posedge clk);
    reqStart <= 1'b0;
    for (i = 0; i < 8 && reqDone !== 1'b1; i++)
      @(posedge clk);
    if (reqDone !== 1'b1)
    begin
      failures++;
      tally_and_finish();
    end
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] expv);
    access(1'b0, a, 8'h00);
    check({8'h00, rspData}, {8'h00, expv});
  endtask : rd

  // Let derived outputs settle
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h08, 8'h38); // Reserved bits left zero
    rd(8'h08, 8'h38);
    settle();
    check(compoundDevice, 1'b1);
    check(autoSwitchEnabled, 1'b0);
    wr(8'h09, 8'h07);
    rd(8'h09, 8'h06);
    wr(8'h0a, 8'h0c); // Contiguous ports 3 and 2
    wr(8'h0b, 8'h03);
    rd(8'h0b, 8'h02);
    rd(8'h0a, 8'h0c);
    powerSourceSelect <= 1'b1;
    settle();
    check(fixedPorts, 3'b011);
    check(selfPoweredActive, 1'b1);
    check(portAvailable, 3'b001);
    powerSourceSelect <= 1'b0;
    settle();
    check(selfPoweredActive, 1'b0);
    check(portAvailable, 3'b110);
    // Automatic switching follows the sense pin against the select bit
    wr(8'h08, 8'h88);
    localSupplySensePin <= 1'b1;
    settle();
    check(autoSwitchEnabled, 1'b1);
    check(selfPoweredActive, 1'b1);
    check(portAvailable, 3'b001);
    localSupplySensePin <= 1'b0;
    powerSourceSelect <= 1'b1;
    settle();
    check(selfPoweredActive, 1'b0);
    check(portAvailable, 3'b110);
    localSupplySensePin <= 1'b1;
    settle();
    check(selfPoweredActive, 1'b1);
    check(portAvailable, 3'b001);
    // Current budget in 2 mA steps, then undefined and locked writes
    wr(8'h0c, 8'h32);
    settle();
    check(selfPoweredBudgetMa, 9'd100);
    wr(8'h0c, 8'h01);
    settle();
    check(selfPoweredBudgetMa, 9'd2);
    wr(8'h0d, 8'h55);
    rd(8'h0d, 8'h00);
    rd(8'h0c, 8'h01);
    cfgWriteLock <= 1'b1;
    wr(8'h0c, 8'h32);
    cfgWriteLock <= 1'b0;
    rd(8'h0c, 8'h01);
    // Over-current delay for every select code
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h08, {2'b00, 2'(s), 4'h0});
      settle();
      @(posedge clk);
      overcurrentSense <= 1'b1;
      n = 0;
      while (overcurrentTrip !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      check(16'((n >= cyc[s] + 2) && (n <= cyc[s] + 6)), 16'h0001);
      overcurrentSense <= 1'b0;
      settle();
      check(overcurrentTrip, 1'b0);
    end
    // Soft reset clears the whole bank
    wr(8'h08, 8'h08);
    @(posedge clk);
    cfgSoftReset <= 1'b1;
    @(posedge clk);
    cfgSoftReset <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    settle();
    check(compoundDevice, 1'b0);
    check(selfPoweredBudgetMa, 9'd0);
    tally_and_finish();
  end
endmodule : test_hub_power_port_config_regs
`default_nettype wire
